// *** hdl/mps_pin_mux.sv ***
// Implementation choices: the placing of the registers and the AXI4-Lite slave port.
`timescale 1ns/100ps
`default_nettype none

module mps_pin_mux (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [5:0] shared_pin_i, // pins 69,70,72,73,40,39
  output logic [5:0] shared_pin_o,
  output logic [5:0] shared_pin_oe,
  input wire logic chan_a_request_send_n_i,
  output logic chan_a_request_send_n_o,
  output logic chan_a_request_send_n_oe,
  input wire logic chan_a_terminal_ready_n_i,
  output logic chan_a_terminal_ready_n_o,
  output logic chan_a_terminal_ready_n_oe,
  input wire logic chan_a_serial_out_i,
  output logic chan_a_serial_out_o,
  output logic chan_a_serial_out_oe,
  input wire logic chan_b_serial_out_i,
  output logic chan_b_serial_out_o,
  output logic chan_b_serial_out_oe,
  output logic strap_pulldown_en,
  input wire logic uart_a_rts_n,
  input wire logic uart_a_dtr_n,
  input wire logic uart_a_sout,
  input wire logic uart_b_sout,
  input wire logic supply_control_req,
  input wire logic pm_event,
  input wire logic panel_switch_out_req,
  input wire logic [5:0] kbc_port_o, // kbc bits 13,14,15,16,20,21
  input wire logic [5:0] kbc_port_oe,
  output logic [5:0] kbc_port_i,
  output logic panel_switch_in_n,
  output logic consumer_ir_receive,
  output logic suspend_c_in_n,
  output logic cfg_port_addr_sel,
  output logic default_clear_bit,
  output logic kbd_ctrl_enable_bit,
  output logic clk48_enable_bit
);

  // ****************************************
  // helpers
  // ****************************************
  // port-two bit number to the keyboard-controller bit it carries as alternate
  function automatic int kbc_idx(input int k);
    case (k)
      0: kbc_idx = mps_pkg::KB_B20;
      5: kbc_idx = mps_pkg::KB_B21;
      default: kbc_idx = k - 1;
    endcase
  endfunction

  function automatic logic is_mapped(input logic [7:0] a);
    is_mapped = (a == mps_pkg::ADR_GLOBAL) || (a == mps_pkg::ADR_CFGADDR) ||
      (a == mps_pkg::ADR_PSEL_A) || (a == mps_pkg::ADR_PSEL_B) ||
      (a == mps_pkg::ADR_PORT2) || (a == mps_pkg::ADR_STATUS);
  endfunction

  // ****************************************
  // pin synchronisers
  // ****************************************
  logic [9:0] lvl;
  logic [5:0] pin_lvl;

  mps_pin_sync #(.W(10)) u_sync (
    .aclk(aclk),
    .d({shared_pin_i, chan_b_serial_out_i, chan_a_serial_out_i,
        chan_a_terminal_ready_n_i, chan_a_request_send_n_i}),
    .q(lvl)
  );
  assign pin_lvl = lvl[mps_pkg::SI_PIN0 +: 6];

  // ****************************************
  // register bus
  // ****************************************
  logic aw_hold_reg, aw_hold_next, w_hold_reg, w_hold_next;
  logic [7:0] awaddr_reg, awaddr_next;
  logic [31:0] wdata_reg, wdata_next;
  logic [3:0] wstrb_reg, wstrb_next;
  logic awready_next, wready_next, bvalid_next, arready_next, rvalid_next;
  logic [1:0] bresp_next, rresp_next;
  logic [31:0] rdata_next;
  logic do_wr;
  logic [7:0] glob_reg, glob_next, cfga_reg, cfga_next, psa_reg, psa_next, psb_reg, psb_next;
  logic [31:0] p2_reg, p2_next;

  assign do_wr = aw_hold_reg && w_hold_reg && !s_axi_bvalid;

  // address and data may arrive in either order; the write happens once both are held
  always_comb begin
    aw_hold_next = aw_hold_reg;
    w_hold_next = w_hold_reg;
    awaddr_next = awaddr_reg;
    wdata_next = wdata_reg;
    wstrb_next = wstrb_reg;
    bvalid_next = s_axi_bvalid;
    bresp_next = s_axi_bresp;
    rvalid_next = s_axi_rvalid;
    rresp_next = s_axi_rresp;
    rdata_next = s_axi_rdata;
    if (s_axi_awvalid && s_axi_awready) begin
      aw_hold_next = 1'b1;
      awaddr_next = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      w_hold_next = 1'b1;
      wdata_next = s_axi_wdata;
      wstrb_next = s_axi_wstrb;
    end
    if (s_axi_bvalid && s_axi_bready) begin
      bvalid_next = 1'b0;
    end
    if (do_wr) begin
      aw_hold_next = 1'b0;
      w_hold_next = 1'b0;
      bvalid_next = 1'b1;
      bresp_next = is_mapped(awaddr_reg) ? mps_pkg::RESP_OKAY : mps_pkg::RESP_SLVERR;
    end
    if (s_axi_rvalid && s_axi_rready) begin
      rvalid_next = 1'b0;
    end
    if (s_axi_arvalid && s_axi_arready) begin
      rvalid_next = 1'b1;
      rresp_next = is_mapped(s_axi_araddr) ? mps_pkg::RESP_OKAY : mps_pkg::RESP_SLVERR;
      case (s_axi_araddr)
        mps_pkg::ADR_GLOBAL: rdata_next = {24'h000000, glob_reg};
        mps_pkg::ADR_CFGADDR: rdata_next = {24'h000000, cfga_reg};
        mps_pkg::ADR_PSEL_A: rdata_next = {24'h000000, psa_reg};
        mps_pkg::ADR_PSEL_B: rdata_next = {24'h000000, psb_reg};
        mps_pkg::ADR_PORT2: rdata_next = p2_reg;
        mps_pkg::ADR_STATUS: rdata_next = {26'h0000000, pin_lvl};
        default: rdata_next = 32'h0000_0000;
      endcase
    end
    // one of each direction in flight keeps the slave free of queues
    awready_next = !aw_hold_next && !bvalid_next;
    wready_next = !w_hold_next && !bvalid_next;
    arready_next = !rvalid_next;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_hold_reg <= 1'b0;
      w_hold_reg <= 1'b0;
      awaddr_reg <= 8'h00;
      wdata_reg <= 32'h0000_0000;
      wstrb_reg <= 4'h0;
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= mps_pkg::RESP_OKAY;
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rresp <= mps_pkg::RESP_OKAY;
      s_axi_rdata <= 32'h0000_0000;
    end else begin
      aw_hold_reg <= aw_hold_next;
      w_hold_reg <= w_hold_next;
      awaddr_reg <= awaddr_next;
      wdata_reg <= wdata_next;
      wstrb_reg <= wstrb_next;
      s_axi_awready <= awready_next;
      s_axi_wready <= wready_next;
      s_axi_bvalid <= bvalid_next;
      s_axi_bresp <= bresp_next;
      s_axi_arready <= arready_next;
      s_axi_rvalid <= rvalid_next;
      s_axi_rresp <= rresp_next;
      s_axi_rdata <= rdata_next;
    end
  end

  // ****************************************
  // configuration registers and straps
  // ****************************************
  // while reset is held the straps are reloaded every edge, so the last level wins
  always_comb begin
    glob_next = glob_reg;
    cfga_next = cfga_reg;
    psa_next = psa_reg;
    psb_next = psb_reg;
    p2_next = p2_reg;
    if (!aresetn) begin
      glob_next = mps_pkg::OPT_RST;
      cfga_next = mps_pkg::OPT_RST;
      glob_next[mps_pkg::GL_CLR] = lvl[mps_pkg::SI_DTR];
      glob_next[mps_pkg::GL_KBC] = lvl[mps_pkg::SI_SOA];
      glob_next[mps_pkg::GL_CLK48] = lvl[mps_pkg::SI_SOB];
      cfga_next[mps_pkg::CA_CFGPORT] = lvl[mps_pkg::SI_RTS];
      psa_next = mps_pkg::PSEL_RST;
      psb_next = mps_pkg::PSEL_RST;
      p2_next = mps_pkg::P2_RST;
    end else if (do_wr) begin
      if (wstrb_reg[0]) begin
        case (awaddr_reg)
          mps_pkg::ADR_GLOBAL: glob_next = wdata_reg[7:0];
          mps_pkg::ADR_CFGADDR: cfga_next = wdata_reg[7:0];
          mps_pkg::ADR_PSEL_A: psa_next = wdata_reg[7:0];
          mps_pkg::ADR_PSEL_B: psb_next = wdata_reg[7:0];
          default: ;
        endcase
      end
      if (awaddr_reg == mps_pkg::ADR_PORT2) begin
        for (int b = 0; b < 4; b++) begin
          if (wstrb_reg[b]) begin
            p2_next[8*b +: 8] = wdata_reg[8*b +: 8] & mps_pkg::P2_MASK[8*b +: 8];
          end
        end
      end
    end
  end

  // sync reset: the strap load above is an ordinary clocked capture
  always_ff @(posedge aclk) begin
    glob_reg <= glob_next;
    cfga_reg <= cfga_next;
    psa_reg <= psa_next;
    psb_reg <= psb_next;
    p2_reg <= p2_next;
  end

  // ****************************************
  // pin routing
  // ****************************************
  logic [1:0] sel_smi, sel_panin, sel_cir;
  logic [5:0] sel_gp;
  logic [5:0] pin_o_next, pin_oe_next, kin_next;
  logic pan_in_next, cir_next, suspend_next;

  assign sel_smi = psb_reg[mps_pkg::B_SMI_LO +: 2];
  assign sel_panin = psb_reg[mps_pkg::B_PANIN_LO +: 2];
  assign sel_cir = psa_reg[mps_pkg::A_CIR_LO +: 2];
  assign sel_gp[mps_pkg::PN_SUPPLY] = p2_reg[mps_pkg::P2_GP69];
  assign sel_gp[mps_pkg::PN_SMI] = (sel_smi == mps_pkg::SEL_GP);
  assign sel_gp[mps_pkg::PN_PANOUT] = psb_reg[mps_pkg::B_PANOUT];
  assign sel_gp[mps_pkg::PN_PANIN] = (sel_panin == mps_pkg::SEL_GP);
  assign sel_gp[mps_pkg::PN_CIR] = (sel_cir == mps_pkg::SEL_GP);
  assign sel_gp[mps_pkg::PN_SUSPEND] = p2_reg[mps_pkg::P2_GP39];

  // default functions first; gp and kbc choices override, odd codes fall through
  always_comb begin
    pin_o_next = 6'h00;
    pin_oe_next = 6'h00;
    kin_next = 6'h3f;
    pin_oe_next[mps_pkg::PN_SUPPLY] = supply_control_req;
    pin_oe_next[mps_pkg::PN_SMI] = p2_reg[mps_pkg::P2_LEGACY] && pm_event;
    pin_oe_next[mps_pkg::PN_PANOUT] = panel_switch_out_req;
    if (sel_smi == mps_pkg::SEL_KBC) begin
      pin_o_next[mps_pkg::PN_SMI] = kbc_port_o[mps_pkg::KB_B16];
      pin_oe_next[mps_pkg::PN_SMI] = kbc_port_oe[mps_pkg::KB_B16];
      kin_next[mps_pkg::KB_B16] = pin_lvl[mps_pkg::PN_SMI];
    end
    if (sel_cir == mps_pkg::SEL_KBC) begin
      pin_o_next[mps_pkg::PN_CIR] = kbc_port_o[mps_pkg::KB_B13];
      pin_oe_next[mps_pkg::PN_CIR] = kbc_port_oe[mps_pkg::KB_B13];
      kin_next[mps_pkg::KB_B13] = pin_lvl[mps_pkg::PN_CIR];
    end
    for (int k = 0; k < 6; k++) begin
      if (sel_gp[k]) begin
        if (p2_reg[mps_pkg::P2_ALT_LO + k]) begin
          pin_o_next[k] = kbc_port_o[kbc_idx(k)];
          pin_oe_next[k] = kbc_port_oe[kbc_idx(k)];
          kin_next[kbc_idx(k)] = pin_lvl[k];
        end else begin
          pin_o_next[k] = p2_reg[k];
          pin_oe_next[k] = p2_reg[mps_pkg::P2_DIR_LO + k];
        end
      end
    end
    pan_in_next = (sel_panin == mps_pkg::SEL_GP) ? 1'b1 : pin_lvl[mps_pkg::PN_PANIN];
    cir_next = (sel_cir == mps_pkg::SEL_GP || sel_cir == mps_pkg::SEL_KBC) ? 1'b1 :
      pin_lvl[mps_pkg::PN_CIR];
    suspend_next = sel_gp[mps_pkg::PN_SUSPEND] ? 1'b1 : pin_lvl[mps_pkg::PN_SUSPEND];
  end

  // strap pins: pulled down and undriven in reset, uart outputs afterwards
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      shared_pin_o <= 6'h00;
      shared_pin_oe <= 6'h00;
      kbc_port_i <= 6'h3f;
      panel_switch_in_n <= 1'b1;
      consumer_ir_receive <= 1'b1;
      suspend_c_in_n <= 1'b1;
      strap_pulldown_en <= 1'b1;
      chan_a_request_send_n_oe <= 1'b0;
      chan_a_terminal_ready_n_oe <= 1'b0;
      chan_a_serial_out_oe <= 1'b0;
      chan_b_serial_out_oe <= 1'b0;
      chan_a_request_send_n_o <= 1'b1;
      chan_a_terminal_ready_n_o <= 1'b1;
      chan_a_serial_out_o <= 1'b1;
      chan_b_serial_out_o <= 1'b1;
    end else begin
      shared_pin_o <= pin_o_next;
      shared_pin_oe <= pin_oe_next;
      kbc_port_i <= kin_next;
      panel_switch_in_n <= pan_in_next;
      consumer_ir_receive <= cir_next;
      suspend_c_in_n <= suspend_next;
      strap_pulldown_en <= 1'b0;
      chan_a_request_send_n_oe <= 1'b1;
      chan_a_terminal_ready_n_oe <= 1'b1;
      chan_a_serial_out_oe <= 1'b1;
      chan_b_serial_out_oe <= 1'b1;
      chan_a_request_send_n_o <= uart_a_rts_n;
      chan_a_terminal_ready_n_o <= uart_a_dtr_n;
      chan_a_serial_out_o <= uart_a_sout;
      chan_b_serial_out_o <= uart_b_sout;
    end
  end

  assign cfg_port_addr_sel = cfga_reg[mps_pkg::CA_CFGPORT];
  assign default_clear_bit = glob_reg[mps_pkg::GL_CLR];
  assign kbd_ctrl_enable_bit = glob_reg[mps_pkg::GL_KBC];
  assign clk48_enable_bit = glob_reg[mps_pkg::GL_CLK48];

  // ****************************************
  // checks
  // ****************************************
  property p_smi_low;
    @(posedge aclk) disable iff (!aresetn)
      (sel_smi != mps_pkg::SEL_GP && sel_smi != mps_pkg::SEL_KBC &&
       p2_reg[mps_pkg::P2_LEGACY] && pm_event) |=> (shared_pin_oe[1] && !shared_pin_o[1]);
  endproperty
  a_smi_low: assert property (p_smi_low) else $error("smi pin not pulled low");

  property p_smi_kbc;
    @(posedge aclk) disable iff (!aresetn)
      (sel_smi == mps_pkg::SEL_KBC) |=> (shared_pin_o[1] == $past(kbc_port_o[3]));
  endproperty
  a_smi_kbc: assert property (p_smi_kbc) else $error("pin 70 not carrying kbc bit 16");

  property p_panout;
    @(posedge aclk) disable iff (!aresetn)
      (!psb_reg[5] && panel_switch_out_req) |=> (shared_pin_oe[2] && !shared_pin_o[2]);
  endproperty
  a_panout: assert property (p_panout) else $error("panel switch output not driven");

  property p_panin;
    @(posedge aclk) disable iff (!aresetn)
      (sel_panin == mps_pkg::SEL_DEF) |=> (!shared_pin_oe[3] && panel_switch_in_n == $past(pin_lvl[3]));
  endproperty
  a_panin: assert property (p_panin) else $error("panel switch input not routed");

  property p_cir_kbc;
    @(posedge aclk) disable iff (!aresetn)
      (sel_cir == mps_pkg::SEL_KBC) |=> (shared_pin_oe[4] == $past(kbc_port_oe[0]));
  endproperty
  a_cir_kbc: assert property (p_cir_kbc) else $error("ir pin not carrying kbc bit 13");

  property p_kbd_reset;
    @(posedge aclk) disable iff (!aresetn)
      (p2_reg[24] && p2_reg[8]) |=> (shared_pin_o[0] == $past(kbc_port_o[4]));
  endproperty
  a_kbd_reset: assert property (p_kbd_reset) else $error("keyboard reset not on pin 69");

  property p_straps;
    @(posedge aclk) disable iff (!aresetn)
      $rose(aresetn) |-> (cfga_reg[6] == $past(lvl[0]) && glob_reg[0] == $past(lvl[1]) &&
        glob_reg[2] == $past(lvl[2]) && glob_reg[6] == $past(lvl[3]));
  endproperty
  a_straps: assert property (p_straps) else $error("strap not latched");

  property p_release;
    @(posedge aclk) disable iff (!aresetn)
      $rose(aresetn) |=> (!strap_pulldown_en && chan_a_serial_out_oe && chan_b_serial_out_oe)
        [*2];
  endproperty
  a_release: assert property (p_release) else $error("strap pins not released");

  property p_odd_code;
    @(posedge aclk) disable iff (!aresetn)
      (sel_smi == 2'h3 && !pm_event) |=> !shared_pin_oe[1];
  endproperty
  a_odd_code: assert property (p_odd_code) else $error("odd select code drives pin");

endmodule

`default_nettype wire

// *** hdl/mps_pkg.sv ***
package mps_pkg;

  // ****************************************
  // register indices and byte addresses
  // ****************************************
  // indices as the device numbers them; the byte address is four times the index
  localparam logic [7:0] IDX_GLOBAL = 8'h24;
  localparam logic [7:0] IDX_CFGADDR = 8'h26;
  localparam logic [7:0] IDX_PSEL_A = 8'h2a;
  localparam logic [7:0] IDX_PSEL_B = 8'h2b;
  localparam logic [7:0] IDX_PORT2 = 8'h30;
  localparam logic [7:0] IDX_STATUS = 8'h31;
  localparam logic [7:0] ADR_GLOBAL = {IDX_GLOBAL[5:0], 2'b00};
  localparam logic [7:0] ADR_CFGADDR = {IDX_CFGADDR[5:0], 2'b00};
  localparam logic [7:0] ADR_PSEL_A = {IDX_PSEL_A[5:0], 2'b00};
  localparam logic [7:0] ADR_PSEL_B = {IDX_PSEL_B[5:0], 2'b00};
  localparam logic [7:0] ADR_PORT2 = {IDX_PORT2[5:0], 2'b00};
  localparam logic [7:0] ADR_STATUS = {IDX_STATUS[5:0], 2'b00};

  // ****************************************
  // field positions
  // ****************************************
  localparam int B_SMI_LO = 3;
  localparam int B_PANOUT = 5;
  localparam int B_PANIN_LO = 6;
  localparam int A_CIR_LO = 4;
  localparam int GL_CLR = 0;
  localparam int GL_KBC = 2;
  localparam int GL_CLK48 = 6;
  localparam int CA_CFGPORT = 6;
  localparam int P2_ALT_LO = 8;
  localparam int P2_DIR_LO = 16;
  localparam int P2_GP69 = 24;
  localparam int P2_GP39 = 25;
  localparam int P2_LEGACY = 28;
  localparam logic [31:0] P2_MASK = 32'h133f_3f3f;

  // ****************************************
  // encodings and reset values
  // ****************************************
  localparam logic [1:0] SEL_DEF = 2'h0;
  localparam logic [1:0] SEL_GP = 2'h1;
  localparam logic [1:0] SEL_KBC = 2'h2;
  localparam logic [7:0] PSEL_RST = 8'h00;
  localparam logic [7:0] OPT_RST = 8'h00;
  localparam logic [31:0] P2_RST = 32'h0000_0000;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // ****************************************
  // indices into pin and keyboard-controller vectors
  // ****************************************
  localparam int SI_RTS = 0;
  localparam int SI_DTR = 1;
  localparam int SI_SOA = 2;
  localparam int SI_SOB = 3;
  localparam int SI_PIN0 = 4;
  localparam int KB_B13 = 0;
  localparam int KB_B14 = 1;
  localparam int KB_B15 = 2;
  localparam int KB_B16 = 3;
  localparam int KB_B20 = 4;
  localparam int KB_B21 = 5;
  localparam int PN_SUPPLY = 0;
  localparam int PN_SMI = 1;
  localparam int PN_PANOUT = 2;
  localparam int PN_PANIN = 3;
  localparam int PN_CIR = 4;
  localparam int PN_SUSPEND = 5;

endpackage

// *** hdl/mps_pin_sync.sv ***
`timescale 1ns/100ps
`default_nettype none

// ****************************************
// three-stage pin synchroniser
// ****************************************
module mps_pin_sync #(
  parameter int W = 10
) (
  input wire logic aclk,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);

  logic [W-1:0] s1_reg;
  logic [W-1:0] s2_reg;
  logic [W-1:0] s3_reg;
  logic [W-1:0] q_next;

  // a level counts once the second and third stages agree
  always_comb begin
    q_next = (s2_reg & s3_reg) | (q & (s2_reg ^ s3_reg));
  end

  // no reset here: straps must be sampled while reset is held
  always_ff @(posedge aclk) begin
    s1_reg <= d;
    s2_reg <= s1_reg;
    s3_reg <= s2_reg;
    q <= q_next;
  end

endmodule

`default_nettype wire

// *** sim/multifunction_pin_select_and_straps_bench.sv ***
`timescale 1ns/100ps
`default_nettype none
`define CHK(a, b, m) begin n_tests++; if ((a) !== (b)) begin failures++; \
  $display("wrong value %0t %s", $time, m); end end

module multifunction_pin_select_and_straps_bench;
  logic aclk = 0;
  logic aresetn = 0;
  logic [7:0] s_axi_awaddr = 0, s_axi_araddr = 0;
  logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0;
  logic s_axi_rready = 0, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  logic s_axi_rvalid;
  logic [31:0] s_axi_wdata = 0, s_axi_rdata, p2, rd;
  logic [3:0] s_axi_wstrb = 0, strap = 0;
  logic [1:0] s_axi_bresp, s_axi_rresp, rs;
  logic [5:0] shared_pin_i, shared_pin_o, shared_pin_oe, kbc_port_i;
  logic [5:0] kbc_port_o = 0, kbc_port_oe = 0, pin_ext = 0;
  logic chan_a_request_send_n_i, chan_a_request_send_n_o, chan_a_request_send_n_oe;
  logic chan_a_terminal_ready_n_i, chan_a_terminal_ready_n_o, chan_a_terminal_ready_n_oe;
  logic chan_a_serial_out_i, chan_a_serial_out_o, chan_a_serial_out_oe;
  logic chan_b_serial_out_i, chan_b_serial_out_o, chan_b_serial_out_oe;
  logic strap_pulldown_en, panel_switch_in_n, consumer_ir_receive, suspend_c_in_n;
  logic cfg_port_addr_sel, default_clear_bit, kbd_ctrl_enable_bit, clk48_enable_bit;
  logic uart_a_rts_n = 0, uart_a_dtr_n = 0, uart_a_sout = 0, uart_b_sout = 0;
  logic supply_control_req = 0, pm_event = 0, panel_switch_out_req = 0;
  logic [7:0] pa, pb;
  int failures = 0, n_tests = 0, cyc = 0, seed = 32'hd5b6;

  // ****************************************
  // pin wiring
  // ****************************************
  // strap bit set = pull-up fitted, clear = weak pull-down wins
  assign chan_a_request_send_n_i = chan_a_request_send_n_oe ? chan_a_request_send_n_o : strap[0];
  assign chan_a_terminal_ready_n_i = chan_a_terminal_ready_n_oe ? chan_a_terminal_ready_n_o :
    strap[1];
  assign chan_a_serial_out_i = chan_a_serial_out_oe ? chan_a_serial_out_o : strap[2];
  assign chan_b_serial_out_i = chan_b_serial_out_oe ? chan_b_serial_out_o : strap[3];
  assign shared_pin_i = (shared_pin_oe & shared_pin_o) | (~shared_pin_oe & pin_ext);

  mps_pin_mux i_mps_pin_mux (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready, .shared_pin_i, .shared_pin_o, .shared_pin_oe,
    .chan_a_request_send_n_i, .chan_a_request_send_n_o, .chan_a_request_send_n_oe,
    .chan_a_terminal_ready_n_i, .chan_a_terminal_ready_n_o, .chan_a_terminal_ready_n_oe,
    .chan_a_serial_out_i, .chan_a_serial_out_o, .chan_a_serial_out_oe, .chan_b_serial_out_i,
    .chan_b_serial_out_o, .chan_b_serial_out_oe, .strap_pulldown_en, .uart_a_rts_n,
    .uart_a_dtr_n, .uart_a_sout, .uart_b_sout, .supply_control_req, .pm_event,
    .panel_switch_out_req, .kbc_port_o, .kbc_port_oe, .kbc_port_i, .panel_switch_in_n,
    .consumer_ir_receive, .suspend_c_in_n, .cfg_port_addr_sel, .default_clear_bit,
    .kbd_ctrl_enable_bit, .clk48_enable_bit);

  // ****************************************
  // clock, watchdog, verdict
  // ****************************************
  always #20 aclk = ~aclk;

  // a hung handshake would otherwise stall forever
  always @(posedge aclk) begin
    cyc++;
    if (cyc == 8000) begin
      failures++;
      results();
    end
  end

  task automatic results;
    if (failures == 0 && n_tests > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask

  // ****************************************
  // bus tasks
  // ****************************************
  // valids drop only at the edge that takes them
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d);
    logic got;
    got = 0;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_wstrb <= 4'hf;
    s_axi_awvalid <= 1;
    s_axi_wvalid <= 1;
    s_axi_bready <= 1;
    while (!got) begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 0;
      if (s_axi_wready) s_axi_wvalid <= 0;
      if (s_axi_bvalid) begin
        rs = s_axi_bresp;
        s_axi_bready <= 0;
        got = 1;
      end
    end
  endtask

  task automatic axi_rd(input logic [7:0] a);
    logic got;
    got = 0;
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1;
    s_axi_rready <= 1;
    while (!got) begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 0;
      if (s_axi_rvalid) begin
        rd = s_axi_rdata;
        rs = s_axi_rresp;
        s_axi_rready <= 0;
        got = 1;
      end
    end
  endtask

  // ****************************************
  // expected pin drive, {enable, value}
  // ****************************************
  function automatic logic [1:0] gpf(int i, int k);
    return p2[8 + i] ? {kbc_port_oe[k], kbc_port_o[k]} : {p2[16 + i], p2[i]};
  endfunction

  function automatic logic [1:0] exp_pin(int i);
    case (i)
      0: return p2[24] ? gpf(0, 4) : {supply_control_req, 1'b0};
      1: return pb[4:3] == 2'h1 ? gpf(1, 0) : pb[4:3] == 2'h2 ? {kbc_port_oe[3], kbc_port_o[3]} :
        {p2[28] & pm_event, 1'b0};
      2: return pb[5] ? gpf(2, 1) : {panel_switch_out_req, 1'b0};
      3: return pb[7:6] == 2'h1 ? gpf(3, 2) : 2'h0;
      4: return pa[5:4] == 2'h1 ? gpf(4, 3) : pa[5:4] == 2'h2 ? {kbc_port_oe[0], kbc_port_o[0]} :
        2'h0;
      default: return p2[25] ? gpf(5, 5) : 2'h0;
    endcase
  endfunction

  // expected level handed to each keyboard-controller bit, 1 where no pin is routed
  function automatic logic [5:0] exp_kin();
    logic [5:0] k, g;
    k = 6'h3f;
    g = {p2[25], pa[5:4] == 2'h1, pb[7:6] == 2'h1, pb[5], pb[4:3] == 2'h1, p2[24]};
    if (pb[4:3] == 2'h2) k[3] = shared_pin_i[1];
    if (pa[5:4] == 2'h2) k[0] = shared_pin_i[4];
    // a port-two alternate wins over the direct keyboard-controller code
    for (int i = 0; i < 6; i++) begin
      if (g[i] && p2[8 + i]) k[i == 0 ? 4 : i == 5 ? 5 : i - 1] = shared_pin_i[i];
    end
    return k;
  endfunction

  // reset with fresh straps; checked again after a mid-run reset
  task automatic do_reset;
    aresetn <= 0;
    strap <= 4'($random(seed));
    repeat (10) @(posedge aclk);
    #1;
    `CHK({strap_pulldown_en, chan_a_serial_out_oe}, 2'h2, "pull-down in reset")
    repeat (10) @(posedge aclk);
    aresetn <= 1;
    repeat (3) @(posedge aclk);
    #1;
    `CHK(cfg_port_addr_sel, strap[0], "cfg port strap")
    `CHK(default_clear_bit, strap[1], "clear strap")
    `CHK(kbd_ctrl_enable_bit, strap[2], "kbc strap")
    `CHK(clk48_enable_bit, strap[3], "clk48 strap")
    `CHK(strap_pulldown_en, 1'b0, "pull-down after reset")
    `CHK({chan_a_serial_out_oe, chan_a_serial_out_o}, {1'b1, uart_a_sout}, "sout a")
    `CHK({chan_b_serial_out_oe, chan_b_serial_out_o}, {1'b1, uart_b_sout}, "sout b")
    axi_rd(mps_pkg::ADR_GLOBAL);
    `CHK(rd, {25'h0, strap[3], 3'h0, strap[2], 1'b0, strap[1]}, "global reg")
    axi_rd(mps_pkg::ADR_CFGADDR);
    `CHK(rd, {25'h0, strap[0], 6'h0}, "cfg addr reg")
  endtask

  // ****************************************
  // main sequence
  // ****************************************
  initial begin
    logic [1:0] e;
    do_reset();
    axi_wr(8'h00, 32'h1);
    `CHK(rs, mps_pkg::RESP_SLVERR, "unmapped write")
    axi_rd(8'hfc);
    `CHK({rs, rd}, {mps_pkg::RESP_SLVERR, 32'h0}, "unmapped read")
    // first pass uses the unlisted codes
    for (int it = 0; it < 24; it++) begin
      @(posedge aclk);
      pa = it == 0 ? 8'h30 : 8'($random(seed));
      pb = it == 0 ? 8'hff : 8'($random(seed));
      p2 = $random(seed) & mps_pkg::P2_MASK;
      kbc_port_o <= 6'($random(seed));
      kbc_port_oe <= 6'($random(seed));
      pin_ext <= 6'($random(seed));
      {pm_event, supply_control_req, panel_switch_out_req, uart_a_sout, uart_a_rts_n, uart_a_dtr_n,
        uart_b_sout} <= 7'($random(seed));
      axi_wr(mps_pkg::ADR_PSEL_A, {24'h0, pa});
      axi_wr(mps_pkg::ADR_PSEL_B, {24'h0, pb});
      axi_wr(mps_pkg::ADR_PORT2, p2);
      `CHK(rs, mps_pkg::RESP_OKAY, "write resp")
      // room for the synchroniser on the input pins
      repeat (8) @(posedge aclk);
      #1;
      for (int i = 0; i < 6; i++) begin
        e = exp_pin(i);
        `CHK(shared_pin_oe[i], e[1], "pin enable")
        if (e[1]) `CHK(shared_pin_o[i], e[0], "pin value")
      end
      `CHK(panel_switch_in_n, pb[7:6] == 2'h1 ? 1'b1 : shared_pin_i[3], "panel in")
      `CHK(consumer_ir_receive, ^pa[5:4] ? 1'b1 : shared_pin_i[4], "ir in")
      `CHK(suspend_c_in_n, p2[25] ? 1'b1 : shared_pin_i[5], "suspend in")
      `CHK(kbc_port_i, exp_kin(), "kbc inputs")
      `CHK({chan_a_request_send_n_oe, chan_a_request_send_n_o, chan_a_terminal_ready_n_oe,
        chan_a_terminal_ready_n_o}, {1'b1, uart_a_rts_n, 1'b1, uart_a_dtr_n}, "rts dtr a")
      `CHK({chan_a_serial_out_o, chan_b_serial_out_o}, {uart_a_sout, uart_b_sout}, "sout")
      axi_rd(mps_pkg::ADR_PSEL_B);
      `CHK(rd, {24'h0, pb}, "psel b readback")
      if (it == 12) do_reset();
    end
    results();
  end
endmodule

`default_nettype wire
